// ### logic/sei_cfg.svh
// constants of the serial eeprom slave: offsets, field positions, resets, timing
`ifndef SEI_CFG_SVH
`define SEI_CFG_SVH

// ****************************************
// timing
// ****************************************
`define SEI_CLK_NS 8
`define SEI_TWR_NS 10000000
`define SEI_TWR_CYC ((`SEI_TWR_NS) / (`SEI_CLK_NS))

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SEI_REG_CTRL 8'h00
`define SEI_REG_STATUS 8'h04
`define SEI_REG_WRCYC 8'h08

// ****************************************
// register fields and reset values
// ****************************************
`define SEI_CTRL_TWO_BLOCK 0
`define SEI_CTRL_RESET 1'b0
`define SEI_WRCYC_W 24

// ****************************************
// control byte fields
// ****************************************
`define SEI_CB_RW 0
`define SEI_CB_LOW 1
`define SEI_CB_MID 2
`define SEI_CB_CODE_LSB 4
`define SEI_CB_CODE_MSB 7

`endif

// ### logic/sei_eeprom.sv
// two-wire serial eeprom slave with page buffer and wishbone status port
`timescale 1ns/1ps
`include "sei_cfg.svh"

module sei_eeprom
#(
  parameter int unsigned WRITE_CYCLES = `SEI_TWR_CYC,
  // device-type code; value is arbitrary
  parameter logic [3:0] DEVICE_CODE = 4'h5
)
(
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic WP_IN,
  input wire logic SUPPLY_LOW_IN,
  input wire sei_pkg::sei_wb_req_type WB_REQ_IN,
  output sei_pkg::sei_wb_rsp_type WB_RSP_OUT
);
  import sei_pkg::*;

  localparam int ADDR_W = 10;
  localparam int WC_W = `SEI_WRCYC_W;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic scl_meta;
  logic scl_s;
  logic scl_d;
  logic sda_meta;
  logic sda_s;
  logic sda_d;
  logic wp_meta;
  logic wp_s;
  logic low_meta;
  logic low_s;
  logic sda_out;

  // bus pins idle high, so the clock and data synchronisers start high to avoid a false START
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      wp_meta <= 1'b0;
      wp_s <= 1'b0;
      low_meta <= 1'b0;
      low_s <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      scl_meta <= SCL_IN;
      scl_s <= scl_meta;
      scl_d <= scl_s;
      sda_meta <= SDA_IN;
      sda_s <= sda_meta;
      sda_d <= sda_s;
      wp_meta <= WP_IN;
      wp_s <= wp_meta;
      low_meta <= SUPPLY_LOW_IN;
      low_s <= low_meta;
      sda_out <= 1'b0;
    end
  end

  // ****************************************
  // state and storage
  // ****************************************
  sei_state_type state;
  sei_state_type after;
  logic [2:0] bit_cnt;
  logic byte_full;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic sda_oe;
  logic master_ack;
  logic have_data;
  logic [ADDR_W-1:0] ptr;
  logic [15:0] pg_valid;
  logic [7:0] pg_buf [0:15];
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic busy;
  logic [WC_W-1:0] wr_cnt;
  logic two_block;
  logic [WC_W-1:0] wr_len;
  sei_wb_rsp_type wb_rsp;

  // ****************************************
  // bus event decode
  // ****************************************
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // clock stays high across both samples, data moves: START or STOP
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire rx_state = (state == ST_CTRL) | (state == ST_ADDR) |
                  (state == ST_WDATA);
  wire byte_end = scl_fall & byte_full;
  // the STOP's own clock pulse shifts in one bit before data rises
  wire byte_bound = (bit_cnt <= 3'h1) & ~byte_full;
  wire code_ok =
    shreg[`SEI_CB_CODE_MSB:`SEI_CB_CODE_LSB] == DEVICE_CODE;
  wire ctrl_ack = code_ok & ~busy;
  wire is_read = shreg[`SEI_CB_RW];
  // high select bit never used; mid bit dropped for the two-block variant
  wire [1:0] blk = {shreg[`SEI_CB_MID] & ~two_block,
                    shreg[`SEI_CB_LOW]};
  wire inhibit = wp_s | low_s;
  wire wr_take = (state == ST_WDATA) & byte_end & ~start_det & ~stop_det;
  wire start_wr = stop_det & (state == ST_WDATA) & byte_bound &
                  have_data & ~inhibit;
  wire wr_done = busy & (wr_cnt <= {{(WC_W-1){1'b0}}, 1'b1});
  wire [7:0] mem_rd = mem[ptr];
  wire [ADDR_W-1:0] ptr_inc = ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [ADDR_W-1:0] ptr_seq = {ptr_inc[ADDR_W-1] & ~two_block,
                               ptr_inc[ADDR_W-2:0]};
  wire [3:0] page_inc = ptr[3:0] + 4'h1;

  // ****************************************
  // protocol engine
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      state <= ST_IDLE;
      after <= ST_IDLE;
      bit_cnt <= 3'h0;
      byte_full <= 1'b0;
      shreg <= 8'h00;
      tx <= 8'h00;
      sda_oe <= 1'b0;
      master_ack <= 1'b0;
      have_data <= 1'b0;
      ptr <= {ADDR_W{1'b0}};
    end
    else if (start_det)
    begin
      // any START, also a repeated one, restarts on a control byte
      state <= ST_CTRL;
      bit_cnt <= 3'h0;
      byte_full <= 1'b0;
      sda_oe <= 1'b0;
      have_data <= 1'b0;
    end
    else if (stop_det)
    begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      byte_full <= 1'b0;
      sda_oe <= 1'b0;
      have_data <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          sda_oe <= 1'b0;
        end
        ST_CTRL, ST_ADDR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            // sampled while clock high, where the master holds it stable
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
              byte_full <= 1'b1;
            end
          end
          else if (byte_end)
          begin
            byte_full <= 1'b0;
            if (state == ST_CTRL)
            begin
              if (ctrl_ack)
              begin
                sda_oe <= 1'b1;
                ptr[ADDR_W-1:ADDR_W-2] <= blk;
                state <= ST_ACK;
                after <= is_read ? ST_TXBYTE : ST_ADDR;
              end
              else
              begin
                state <= ST_IDLE;
              end
            end
            else if (state == ST_ADDR)
            begin
              ptr[7:0] <= shreg;
              sda_oe <= 1'b1;
              state <= ST_ACK;
              after <= ST_WDATA;
            end
            else
            begin
              ptr[3:0] <= page_inc;
              have_data <= 1'b1;
              sda_oe <= 1'b1;
              state <= ST_ACK;
              after <= ST_WDATA;
            end
          end
        end
        ST_ACK:
        begin
          // release at the end of the ninth pulse, while clock is low, or put out the first read bit
          if (scl_fall)
          begin
            bit_cnt <= 3'h0;
            state <= after;
            if (after == ST_TXBYTE)
            begin
              tx <= mem_rd;
              ptr <= ptr_seq;
              sda_oe <= ~mem_rd[7];
            end
            else
            begin
              sda_oe <= 1'b0;
            end
          end
        end
        ST_TXBYTE:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == 3'h7)
            begin
              sda_oe <= 1'b0;
              bit_cnt <= 3'h0;
              master_ack <= 1'b0;
              state <= ST_TXACK;
            end
            else
            begin
              bit_cnt <= bit_cnt + 3'h1;
              tx <= {tx[6:0], 1'b0};
              sda_oe <= ~tx[6];
            end
          end
        end
        ST_TXACK:
        begin
          if (scl_rise)
          begin
            master_ack <= ~sda_s;
          end
          else if (scl_fall)
          begin
            if (master_ack)
            begin
              tx <= mem_rd;
              ptr <= ptr_seq;
              sda_oe <= ~mem_rd[7];
              state <= ST_TXBYTE;
            end
            else
            begin
              // line stays released so the master can send STOP
              sda_oe <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // page buffer and write cycle
  // ****************************************
  // buffer survives polling STARTs while busy; cleared once committed
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      pg_valid <= 16'h0000;
    end
    else if (wr_done || ((start_det || stop_det) && !busy && !start_wr))
    begin
      pg_valid <= 16'h0000;
    end
    else if (wr_take)
    begin
      pg_valid[ptr[3:0]] <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (wr_take)
    begin
      pg_buf[ptr[3:0]] <= shreg;
    end
  end

  // commit at the end of the timed cycle; a late supply drop still blocks it
  always_ff @(posedge CLK_IN)
  begin
    if (wr_done && !low_s)
    begin
      for (int i = 0; i < 16; i++)
      begin
        if (pg_valid[i])
        begin
          mem[{ptr[ADDR_W-1:4], 4'(i)}] <= pg_buf[i];
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      busy <= 1'b0;
      wr_cnt <= {WC_W{1'b0}};
    end
    else if (start_wr)
    begin
      busy <= 1'b1;
      wr_cnt <= wr_len;
    end
    else if (wr_done)
    begin
      busy <= 1'b0;
    end
    else if (busy)
    begin
      wr_cnt <= wr_cnt - {{(WC_W-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  wire wb_take = WB_REQ_IN.cyc & WB_REQ_IN.stb & ~wb_rsp.ack;
  // writes land at the ack edge, while the master still holds the request
  wire wb_wr = WB_REQ_IN.cyc & WB_REQ_IN.stb & WB_REQ_IN.we & wb_rsp.ack;
  wire sel_ctrl = WB_REQ_IN.adr == `SEI_REG_CTRL;
  wire sel_stat = WB_REQ_IN.adr == `SEI_REG_STATUS;
  wire sel_wrcyc = WB_REQ_IN.adr == `SEI_REG_WRCYC;
  wire [31:0] stat_word = {14'h0000, ptr, 5'h00, low_s, wp_s, busy};
  wire [31:0] rd_word =
    sel_ctrl ? {31'h0000_0000, two_block} :
    sel_stat ? stat_word :
    sel_wrcyc ? {8'h00, wr_len} :
    32'h0000_0000;

  // one wait state: ack one edge after the request, dropped the next
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      wb_rsp <= '0;
      two_block <= `SEI_CTRL_RESET;
      wr_len <= WC_W'(WRITE_CYCLES);
    end
    else
    begin
      wb_rsp.ack <= wb_take;
      wb_rsp.dat <= wb_take ? rd_word : 32'h0000_0000;
      if (wb_wr && sel_ctrl && WB_REQ_IN.sel[0])
      begin
        two_block <= WB_REQ_IN.dat[`SEI_CTRL_TWO_BLOCK];
      end
      if (wb_wr && sel_wrcyc)
      begin
        for (int b = 0; b < 3; b++)
        begin
          if (WB_REQ_IN.sel[b])
          begin
            wr_len[b*8 +: 8] <= WB_REQ_IN.dat[b*8 +: 8];
          end
        end
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign SDA_OUT = sda_out;
  assign SDA_OE_OUT = sda_oe;
  assign WB_RSP_OUT = wb_rsp;

endmodule : sei_eeprom

// ### logic/sei_pkg.sv
// types shared by the serial eeprom slave
package sei_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_WDATA,
    ST_ACK,
    ST_TXBYTE,
    ST_TXACK
  } sei_state_type;

  typedef struct packed
  {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sei_wb_req_type;

  typedef struct packed
  {
    logic ack;
    logic [31:0] dat;
  } sei_wb_rsp_type;

endpackage : sei_pkg

// ### verification/sei_eeprom_assertions.sv
// port assertions for the serial eeprom slave
`timescale 1ns/1ps
module sei_eeprom_assertions
(
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic WP_IN,
  input wire logic SUPPLY_LOW_IN,
  input wire sei_pkg::sei_wb_req_type WB_REQ_IN,
  input wire sei_pkg::sei_wb_rsp_type WB_RSP_OUT
);
  import sei_pkg::*;
  // ******
  // checks
  // ******
  wire logic take = WB_REQ_IN.cyc && WB_REQ_IN.stb && !WB_RSP_OUT.ack;
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  open_drain_a: assert property (SDA_OUT == 1'b0)
    else $error("data pin driven high");
  oe_hold_a: assert property (SCL_IN && $past(SCL_IN) |->
    $stable(SDA_OE_OUT)) else $error("data moved while clock high");
  oe_late_a: assert property ($rose(SDA_OE_OUT) |->
    !SCL_IN && !$past(SCL_IN, 2)) else $error("pull near clock high");
  oe_stand_a: assert property ($rose(SDA_OE_OUT) |->
    SDA_OE_OUT [*8]) else $error("pull too short");
  release_a: assert property ($fell(SDA_OE_OUT) |-> !SCL_IN)
    else $error("release while clock high");
  wb_answer_a: assert property (take |=> WB_RSP_OUT.ack)
    else $error("request unanswered");
  wb_pulse_a: assert property (WB_RSP_OUT.ack |=> !WB_RSP_OUT.ack)
    else $error("answer too long");
  wb_quiet_a: assert property (!take |=> !WB_RSP_OUT.ack)
    else $error("answer without request");
  wb_unmapped_a: assert property (take && !WB_REQ_IN.we &&
    WB_REQ_IN.adr > 8'h0B |=> WB_RSP_OUT.dat == '0)
    else $error("unmapped read not zero");
  cover property ($rose(SDA_OE_OUT));
  cover property (WB_RSP_OUT.ack && !WB_REQ_IN.we);
  cover property (WP_IN && SDA_OE_OUT);
endmodule : sei_eeprom_assertions

bind sei_eeprom sei_eeprom_assertions u_chk
(
  .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT),
  .WP_IN(WP_IN), .SUPPLY_LOW_IN(SUPPLY_LOW_IN),
  .WB_REQ_IN(WB_REQ_IN), .WB_RSP_OUT(WB_RSP_OUT)
);

// ### verification/sei_eeprom_tb.sv
// self-checking bench of the serial eeprom slave
`timescale 1ns/1ps
module sei_eeprom_tb;
  import sei_pkg::*;
  // ******
  // setup; a short write cycle keeps the run brief
  // ******
  localparam int unsigned WCYC = 400;
  // device-type code; value is arbitrary
  localparam logic [3:0] CODE = 4'h5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp = 1'b0;
  logic low = 1'b0;
  logic scl, pull, got, oe;
  logic [31:0] val;
  logic [63:0] exp_q[$];
  logic [7:0] pg[16];
  logic [7:0] v0, v3;
  int err_total = 0;
  int n_tests = 0;
  sei_wb_req_type req = '0;
  sei_wb_rsp_type rsp;
  wire logic sda = ~(oe | pull);
  always #4 clk = ~clk;
  sei_eeprom #(.WRITE_CYCLES(WCYC), .DEVICE_CODE(CODE)) dut
  (
    .CLK_IN(clk), .RESETN_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE_OUT(oe), .WP_IN(wp), .SUPPLY_LOW_IN(low),
    .WB_REQ_IN(req), .WB_RSP_OUT(rsp)
  );
  sei_master_model m
  (
    .clk_in(clk), .sda_in(sda), .scl_out(scl), .pull_out(pull),
    .got_out(got), .val_out(val)
  );
  // ******
  // tasks
  // ******
  task ex(input logic [31:0] v, input logic [31:0] msk = '1);
    exp_q.push_back({msk, v});
  endtask : ex
  task cmp_link(input logic [31:0] g);
    logic [63:0] e;
    e = exp_q.pop_front();
    n_tests++;
    if ((g & e[63:32]) !== e[31:0])
    begin
      err_total++;
      $display("[FAIL] %0t link exp %h got %h", $time, e[31:0], g);
    end
  endtask : cmp_link
  task cmp_wb(input logic [31:0] g);
    logic [63:0] e;
    e = exp_q.pop_front();
    n_tests++;
    if ((g & e[63:32]) !== e[31:0])
    begin
      err_total++;
      $display("[FAIL] %0t bus exp %h got %h", $time, e[31:0], g);
    end
  endtask : cmp_wb
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    // no fixed latency assumed; the wait ends on ack, or else only at the watchdog
    do @(posedge clk); while (rsp.ack !== 1'b1);
    req <= '0;
    @(posedge clk);
  endtask : wb
  task ctl(input logic [1:0] k, input logic rd, input logic e);
    ex({31'h0, e});
    m.wbyte({CODE, 1'b1, k, rd});
  endtask : ctl
  task wr1(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
    m.start;
    ctl(k, 1'b0, 1'b0);
    ex('0);
    m.wbyte(a);
    ex('0);
    m.wbyte(d);
    m.stop;
  endtask : wr1
  task rread(input logic [1:0] k, input logic [7:0] a);
    ctl(k, 1'b0, 1'b0);
    ex('0);
    m.wbyte(a);
    m.start;
    ctl(k, 1'b1, 1'b0);
  endtask : rread
  task final_report;
    // a result that never came counts as a mismatch
    if (exp_q.size() != 0) err_total++;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // results are taken in the order they were noted
  always @(posedge clk)
  begin
    if (got === 1'b1) cmp_link(val);
    if (rsp.ack === 1'b1) cmp_wb(rsp.dat);
  end
  initial
  begin
    #400000;
    err_total++;
    final_report;
  end
  // ******
  // scenarios
  // ******
  initial
  begin
    void'($urandom(32'h6CEF));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    ex(32'(WCYC));
    wb(1'b0, 8'h08, '0);
    ex('0);
    wb(1'b0, 8'h40, '0);
    ex('0, '0);
    wb(1'b1, 8'h00, '0);
    ex('0, '0);
    wb(1'b1, 8'h08, 32'hFF00_0123);
    ex(32'h0000_0123);
    wb(1'b0, 8'h08, '0);
    ex('0, '0);
    wb(1'b1, 8'h08, 32'(WCYC));
    m.start;
    ex(32'h1);
    m.wbyte({CODE ^ 4'h1, 4'h0});
    m.stop;
    m.start;
    ctl(2'b10, 1'b0, 1'b0);
    ex('0);
    m.wbyte(8'hF8);
    for (int i = 0; i < 18; i++)
    begin
      pg[(i + 8) % 16] = 8'($urandom);
      ex('0);
      m.wbyte(pg[(i + 8) % 16]);
    end
    m.stop;
    ex(32'h1, 32'h1);
    wb(1'b0, 8'h04, '0);
    m.start;
    ctl(2'b10, 1'b0, 1'b1);
    m.stop;
    repeat (WCYC) @(posedge clk);
    m.start;
    rread(2'b10, 8'hF0);
    for (int i = 0; i < 16; i++)
    begin
      ex({24'h0, pg[i]});
      m.rbyte(i == 15);
    end
    m.stop;
    v0 = 8'($urandom);
    wr1(2'b00, 8'h00, v0);
    repeat (WCYC + 20) @(posedge clk);
    for (int k = 0; k < 2; k++)
    begin
      wp <= (k == 0);
      low <= (k == 1);
      wr1(2'b00, 8'h00, ~v0);
      // protected: pointer moved on, no write cycle began
      ex(32'h100 | 32'({k == 1, k == 0, 1'b0}));
      wb(1'b0, 8'h04, '0);
      m.start;
      rread(2'b00, 8'h00);
      ex({24'h0, v0});
      m.rbyte(1'b1);
      m.stop;
    end
    wp <= 1'b0;
    low <= 1'b0;
    v3 = 8'($urandom);
    wr1(2'b11, 8'hFF, v3);
    repeat (WCYC + 20) @(posedge clk);
    m.start;
    rread(2'b11, 8'hFF);
    ex({24'h0, v3});
    m.rbyte(1'b0);
    ex({24'h0, v0});
    m.rbyte(1'b1);
    m.stop;
    ex('0, '0);
    wb(1'b1, 8'h00, 32'h1);
    ex(32'h1);
    wb(1'b0, 8'h00, '0);
    // two blocks: mid select ignored, so this lands at 0x1FF
    wr1(2'b11, 8'hFF, ~v3);
    repeat (WCYC + 20) @(posedge clk);
    m.start;
    rread(2'b11, 8'hFF);
    ex({24'h0, ~v3});
    m.rbyte(1'b0);
    ex({24'h0, v0});
    m.rbyte(1'b1);
    m.stop;
    ex('0, '0);
    wb(1'b1, 8'h00, '0);
    m.start;
    rread(2'b11, 8'hFF);
    ex({24'h0, v3});
    m.rbyte(1'b1);
    m.stop;
    m.start;
    ctl(2'b00, 1'b0, 1'b0);
    ex('0);
    m.wbyte(8'h01);
    // a full data byte, then a cut one: the STOP must not program
    ex('0);
    m.wbyte(8'h5A);
    m.wbyte(8'hA5, 4);
    m.stop;
    m.start;
    ctl(2'b00, 1'b0, 1'b0);
    m.stop;
    final_report;
  end
endmodule : sei_eeprom_tb

// ### verification/sei_master_model.sv
// two-wire bus master that drives transfers for the eeprom bench
`timescale 1ns/1ps
module sei_master_model
(
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic pull_out,
  output logic got_out,
  output logic [31:0] val_out
);
  // ******
  // phases: five clocks a quarter bit, 160 ns a bit
  // ******
  initial
  begin
    scl_out = 1'b1;
    pull_out = 1'b0;
    got_out = 1'b0;
    val_out = '0;
  end
  task q;
    repeat (5) @(posedge clk_in);
  endtask : q
  task put(input logic [31:0] v);
    val_out <= v;
    got_out <= 1'b1;
    @(posedge clk_in);
    got_out <= 1'b0;
  endtask : put
  // also serves as repeated start, since it first releases data
  task start;
    pull_out <= 1'b0;
    q;
    scl_out <= 1'b1;
    q;
    pull_out <= 1'b1;
    q;
    scl_out <= 1'b0;
    q;
  endtask : start
  // leaves both lines high, so the clock stands still between frames
  task stop;
    pull_out <= 1'b1;
    q;
    scl_out <= 1'b1;
    q;
    pull_out <= 1'b0;
    q;
  endtask : stop
  task bitx(input logic b, output logic s);
    pull_out <= !b;
    q;
    scl_out <= 1'b1;
    q;
    s = sda_in;
    q;
    scl_out <= 1'b0;
    q;
  endtask : bitx
  task wbyte(input logic [7:0] b, input int n = 8);
    logic s;
    for (int i = 7; i > 7 - n; i--) bitx(b[i], s);
    if (n == 8)
    begin
      bitx(1'b1, s);
      put({31'h0, s});
    end
  endtask : wbyte
  task rbyte(input logic last);
    logic [7:0] d;
    logic s;
    for (int i = 0; i < 8; i++)
    begin
      bitx(1'b1, s);
      d = {d[6:0], s};
    end
    bitx(last, s);
    put({24'h0, d});
  endtask : rbyte
endmodule : sei_master_model
